// file: amss_pkg.sv
package amss_pkg;
    // pclk rate and converter rate ceilings
    localparam int CLK_MHZ = 250;
    localparam int CONV_MAX_MHZ_MULTI = 45;
    localparam int CONV_MAX_MHZ_SINGLE = 30;
    localparam logic [7:0] CONV_MIN_CYC_MULTI = 8'((CLK_MHZ + CONV_MAX_MHZ_MULTI - 1) / CONV_MAX_MHZ_MULTI);
    localparam logic [7:0] CONV_MIN_CYC_SINGLE = 8'((CLK_MHZ + CONV_MAX_MHZ_SINGLE - 1) / CONV_MAX_MHZ_SINGLE);
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIV = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_CHAN = 8'h10;
    localparam logic [7:0] ADDR_LINE = 8'h20;
    // mode, channel and pair codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_TWO = 2'h1;
    localparam logic [1:0] MODE_THREE = 2'h2;
    localparam logic [1:0] CH_RED = 2'h0;
    localparam logic [1:0] CH_GREEN = 2'h1;
    localparam logic [1:0] CH_BLUE = 2'h2;
    localparam logic [1:0] PAIR_GB = 2'h0;
    localparam logic [1:0] PAIR_RG = 2'h1;
    localparam int NUM_LINE_COEF = 5;
    localparam int GAIN_SHIFT = 6;
    // reset values
    localparam logic [11:0] CTRL_RST = 12'h100;
    localparam logic [7:0] DIV_RST = 8'h0c;
    localparam logic [15:0] COEF_RST = 16'h4000;
    typedef struct packed {
        logic descend;
        logic [2:0] seq_len;
        logic [1:0] in_sel;
        logic [1:0] pair;
        logic reverse;
        logic pix_rate;
        logic [1:0] mode;
    } amss_ctrl_s;
    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] offset;
    } amss_coef_s;
    typedef struct packed {
        logic [1:0] chan;
        logic [2:0] coef;
        logic [15:0] data;
    } amss_pix_s;
endpackage : amss_pkg

// file: amss_fifo.sv
`timescale 1ns/100ps
module amss_fifo #(
    parameter int W = 21,
    parameter int D = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt;
    logic wr, rd;
    // honest full and empty from the fill count
    assign in_ready = (cnt != (AW+1)'(D));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;
    // pointers wrap at depth
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem <= '0;
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            if (wr)
            begin
                mem[wp] <= in_data;
                wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
            end
            if (rd)
                rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
            cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end
endmodule : amss_fifo

// file: amss_sequencer.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
module amss_sequencer
    import amss_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_sync_pulse,
    input wire logic [15:0] red_sensor_input,
    input wire logic [15:0] green_sensor_input,
    input wire logic [15:0] blue_sensor_input,
    output logic [15:0] conv_data,
    output logic [1:0] conv_chan,
    output logic [2:0] conv_coef,
    output logic conv_valid,
    input wire logic conv_ready
);
    typedef struct packed {
        logic [2:0][15:0] s1;
        logic [2:0][15:0] s2;
        logic [2:0][15:0] hold;
        logic ls1;
        logic ls2;
        logic ls3;
        amss_ctrl_s ctrl;
        logic [7:0] div;
        logic [2:0][15:0] chan_coef;
        logic [NUM_LINE_COEF-1:0][15:0] line_coef;
        logic [8:0] acc;
        logic [1:0] phase;
        logic [2:0] coef_idx;
        logic armed;
        logic ack;
        logic [31:0] prdata;
        logic pslverr;
    } amss_state_s;

    amss_state_s st, next_st;
    amss_pix_s pix, fifo_out;
    amss_coef_s cf;
    logic fifo_ready, fifo_valid, sync_edge, tick, push, multi_rate, wr_en;
    logic [1:0] nslots, ch, even_ch, odd_ch;
    logic [2:0] len;
    logic [7:0] min_cyc, eff;
    logic [8:0] acc_sum;
    logic [2:0][15:0] smp;

    // offset then gain, saturated to the converter range
    function automatic logic [15:0] amss_correct(input logic [15:0] v, input amss_coef_s c);
        logic signed [17:0] s;
        logic signed [26:0] p;
        logic signed [26:0] q;
        s = $signed({2'b00, v}) + 18'(signed'(c.offset));
        if (s < 0)
            s = '0;
        p = s * $signed({1'b0, c.gain});
        q = p >>> GAIN_SHIFT;
        if (q > 27'sh000ffff)
            return 16'hffff;
        return q[15:0];
    endfunction : amss_correct

    // line sync edge, slots per pixel and rate limits
    always_comb
    begin
        sync_edge = st.ls2 && !st.ls3;
        len = (st.ctrl.seq_len == 3'h0) ? 3'h1 : (st.ctrl.seq_len > 3'h5) ? 3'h5 : st.ctrl.seq_len;
        case (st.ctrl.mode)
            MODE_THREE: nslots = 2'h3;
            MODE_TWO: nslots = 2'h2;
            default: nslots = 2'h1;
        endcase
        multi_rate = st.ctrl.pix_rate && (st.ctrl.mode != MODE_SINGLE);
        if (st.ctrl.mode == MODE_SINGLE)
            min_cyc = CONV_MIN_CYC_SINGLE;
        else if (multi_rate)
            min_cyc = 8'(nslots) * CONV_MIN_CYC_MULTI;
        else
            min_cyc = CONV_MIN_CYC_MULTI;
        eff = (st.div < min_cyc) ? min_cyc : st.div;
        acc_sum = st.acc + (multi_rate ? 9'(nslots) : 9'h1);
        tick = acc_sum >= {1'b0, eff};
    end

    // channel routing per mode and slot
    always_comb
    begin
        case (st.ctrl.pair)
            PAIR_GB:
            begin
                even_ch = CH_BLUE;
                odd_ch = CH_GREEN;
            end
            PAIR_RG:
            begin
                even_ch = CH_RED;
                odd_ch = CH_GREEN;
            end
            default:
            begin
                even_ch = CH_BLUE;
                odd_ch = CH_RED;
            end
        endcase
        case (st.ctrl.mode)
            MODE_THREE: ch = st.ctrl.reverse ? 2'h2 - st.phase : st.phase;
            MODE_TWO: ch = ((st.phase == 2'h0) != st.ctrl.reverse) ? even_ch : odd_ch;
            default: ch = (st.ctrl.in_sel == 2'h3) ? CH_RED : st.ctrl.in_sel;
        endcase
        smp = (st.phase == 2'h0) ? st.s2 : st.hold;
        pix.chan = ch;
        pix.coef = 3'h0;
        cf = st.chan_coef[ch];
        if (st.ctrl.mode == MODE_SINGLE && ch == CH_RED && len > 3'h1)
        begin
            cf = st.line_coef[st.coef_idx];
            pix.coef = st.coef_idx;
        end
        pix.data = amss_correct(smp[ch], cf);
        push = tick && st.armed && fifo_ready;
    end

    // next state: synchronisers, sequencing, apb
    always_comb
    begin
        next_st = st;
        next_st.s1 = {blue_sensor_input, green_sensor_input, red_sensor_input};
        next_st.s2 = st.s1;
        next_st.ls1 = line_sync_pulse;
        next_st.ls2 = st.ls1;
        next_st.ls3 = st.ls2;
        // converter tick stalls while the fifo is full
        if (!(tick && st.armed && !fifo_ready))
            next_st.acc = tick ? acc_sum - {1'b0, eff} : acc_sum;
        if (push)
        begin
            if (st.phase == 2'h0)
                next_st.hold = st.s2;
            next_st.phase = (st.phase == nslots - 2'h1) ? 2'h0 : st.phase + 2'h1;
        end
        // line sync aligns the slot order and steps coefficients
        if (sync_edge)
        begin
            next_st.phase = 2'h0;
            next_st.acc = '0;
            next_st.armed = 1'b1;
            if (!st.armed)
                next_st.coef_idx = st.ctrl.descend ? len - 3'h1 : 3'h0;
            else if (st.ctrl.descend)
                next_st.coef_idx = (st.coef_idx == 3'h0) ? len - 3'h1 : st.coef_idx - 3'h1;
            else
                next_st.coef_idx = (st.coef_idx >= len - 3'h1) ? 3'h0 : st.coef_idx + 3'h1;
        end
        // apb: one wait state, write lands at the pready edge; error flag stands one cycle with pready
        next_st.pslverr = 1'b0;
        next_st.ack = psel && penable && !st.ack;
        if (psel && penable && !st.ack)
        begin
            next_st.prdata = '0;
            next_st.pslverr = 1'b0;
            if (paddr == ADDR_CTRL)
                next_st.prdata = 32'(st.ctrl);
            else if (paddr == ADDR_DIV)
                next_st.prdata = 32'(st.div);
            else if (paddr == ADDR_STAT)
                next_st.prdata = {24'h0, !fifo_ready, st.armed, st.coef_idx, 1'b0, st.phase};
            else if (paddr >= ADDR_CHAN && paddr < ADDR_CHAN + 8'h0c && paddr[1:0] == 2'h0)
                next_st.prdata = 32'(st.chan_coef[paddr[3:2]]);
            else if (paddr >= ADDR_LINE && paddr < ADDR_LINE + 8'h14 && paddr[1:0] == 2'h0)
                next_st.prdata = 32'(st.line_coef[3'(paddr[4:2])]);
            else
                next_st.pslverr = 1'b1;
        end
        wr_en = psel && penable && st.ack && pwrite && !st.pslverr;
        if (wr_en)
        begin
            if (paddr == ADDR_CTRL)
            begin
                next_st.ctrl = pwdata[11:0];
                next_st.armed = 1'b0;
                next_st.phase = 2'h0;
            end
            else if (paddr == ADDR_DIV)
                next_st.div = pwdata[7:0];
            else if (paddr >= ADDR_CHAN && paddr < ADDR_CHAN + 8'h0c)
                next_st.chan_coef[paddr[3:2]] = pwdata[15:0];
            else if (paddr >= ADDR_LINE && paddr < ADDR_LINE + 8'h14)
                next_st.line_coef[3'(paddr[4:2])] = pwdata[15:0];
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.ctrl <= CTRL_RST;
            st.div <= DIV_RST;
            st.chan_coef <= {3{COEF_RST}};
            st.line_coef <= {NUM_LINE_COEF{COEF_RST}};
        end
        else
            st <= next_st;
    end

    amss_fifo #(.W($bits(amss_pix_s)), .D(FIFO_DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_data(pix),
        .in_valid(tick && st.armed),
        .in_ready(fifo_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(conv_ready)
    );

    // outputs from state and fifo storage
    assign prdata = st.prdata;
    assign pready = st.ack;
    assign pslverr = st.pslverr;
    assign conv_data = fifo_out.data;
    assign conv_chan = fifo_out.chan;
    assign conv_coef = fifo_out.coef;
    assign conv_valid = fifo_valid;

    sequence s_first_sync;
        sync_edge && !st.armed;
    endsequence
    sequence s_restarted;
        st.armed && st.phase == 2'h0 && st.coef_idx == (st.ctrl.descend ? len - 3'h1 : 3'h0);
    endsequence

    property p_three_order;
        @(posedge pclk) disable iff (!presetn)
        push && st.ctrl.mode == MODE_THREE && st.phase == 2'h0 |-> pix.chan == (st.ctrl.reverse ? CH_BLUE : CH_RED);
    endproperty
    a_three_order: assert property (p_three_order) else $error("three-channel order wrong");
    property p_sim_sample;
        @(posedge pclk) disable iff (!presetn)
        push && st.phase == 2'h0 |=> st.hold == $past(st.s2);
    endproperty
    a_sim_sample: assert property (p_sim_sample) else $error("inputs not held together");
    property p_tick_space;
        @(posedge pclk) disable iff (!presetn)
        tick && !sync_edge && !(st.armed && !fifo_ready) |=> !tick [*5]; // a tick held by a full fifo is not a new one
    endproperty
    a_tick_space: assert property (p_tick_space) else $error("converter faster than limit");
    property p_two_default;
        @(posedge pclk) disable iff (!presetn)
        push && st.ctrl.mode == MODE_TWO && st.ctrl.pair == PAIR_GB && !st.ctrl.reverse |->
            pix.chan == (st.phase == 2'h0 ? CH_BLUE : CH_GREEN);
    endproperty
    a_two_default: assert property (p_two_default) else $error("even/odd routing wrong");
    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        s_first_sync |=> s_restarted;
    endproperty
    a_restart: assert property (p_restart) else $error("first sync did not restart");
    property p_step_up;
        @(posedge pclk) disable iff (!presetn)
        sync_edge && st.armed && !st.ctrl.descend && st.coef_idx < len - 3'h1 |=> st.coef_idx == $past(st.coef_idx) + 3'h1;
    endproperty
    a_step_up: assert property (p_step_up) else $error("coefficient set did not advance");
    property p_mono_coef;
        @(posedge pclk) disable iff (!presetn)
        push && st.ctrl.mode == MODE_SINGLE && pix.chan != CH_RED |-> pix.coef == 3'h0;
    endproperty
    a_mono_coef: assert property (p_mono_coef) else $error("green/blue used line sets");
    property p_pready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");
endmodule : amss_sequencer

// file: amss_sensor_model.sv
`timescale 1ns/100ps
// sensor side: line sync strobe and pixel levels held for a whole line
module amss_sensor_model (
    input wire logic pclk,
    output logic line_sync_pulse,
    output logic [15:0] red_sensor_input,
    output logic [15:0] green_sensor_input,
    output logic [15:0] blue_sensor_input
);
    // idle levels before the first line
    initial
    begin
        line_sync_pulse = 1'b0;
        red_sensor_input = 16'h0000;
        green_sensor_input = 16'h0000;
        blue_sensor_input = 16'h0000;
    end
    // start of a line: levels change with the strobe, strobe is long enough for two sync flops
    task automatic new_line(input logic [3:0] num);
        @(posedge pclk);
        line_sync_pulse <= 1'b1;
        red_sensor_input <= {4'h1, num, 8'h00};
        green_sensor_input <= {4'h2, num, 8'h00};
        blue_sensor_input <= {4'h3, num, 8'h00};
        repeat (4) @(posedge pclk);
        line_sync_pulse <= 1'b0;
    endtask : new_line
endmodule : amss_sensor_model

// file: amss_sequencer_test.sv
`timescale 1ns/100ps
module amss_sequencer_test
    import amss_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_sync_pulse, conv_valid, conv_ready, re;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [15:0] red_sensor_input, green_sensor_input, blue_sensor_input, conv_data, pd;
    logic [15:0] ev [3];
    logic [1:0] conv_chan, pc, ev_n, od_n;
    logic [2:0] conv_coef, pk;
    logic [3:0] lnum;
    int mismatches, checks_done, cyc, last_pop, gap, ro, rg, p, r, pr;
    amss_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_sync_pulse(line_sync_pulse), .red_sensor_input(red_sensor_input),
        .green_sensor_input(green_sensor_input), .blue_sensor_input(blue_sensor_input),
        .conv_data(conv_data), .conv_chan(conv_chan), .conv_coef(conv_coef), .conv_valid(conv_valid),
        .conv_ready(conv_ready));
    amss_sensor_model sensor (.pclk(pclk), .line_sync_pulse(line_sync_pulse), .red_sensor_input(red_sensor_input),
        .green_sensor_input(green_sensor_input), .blue_sensor_input(blue_sensor_input));
    // clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // cycle count and hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer; read data and error land in rq and re
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb_wait", 2, n);
    endtask : apb
    // reference correction of the red path
    function automatic logic [15:0] corr(input logic [15:0] s);
        int v;
        v = int'(s) + ro;
        if (v < 0)
            v = 0;
        v = (v * rg) >> 6;
        if (v > 65535)
            v = 65535;
        return v[15:0];
    endfunction : corr
    task automatic line();
        lnum++;
        ev[0] = corr({4'h1, lnum, 8'h00});
        ev[1] = {4'h2, lnum, 8'h00};
        ev[2] = {4'h3, lnum, 8'h00};
        sensor.new_line(lnum);
    endtask : line
    // take one pixel; on a fresh line a few leftovers of the old line may be skipped
    task automatic pop(input bit fresh);
        int n, s;
        n = 0;
        s = 0;
        while (n < 400)
        begin
            @(posedge pclk);
            n++;
            if (conv_valid === 1'b1 && conv_ready === 1'b1)
            begin
                if (!fresh || conv_data === ev[0] || conv_data === ev[1] || conv_data === ev[2])
                    break;
                s++;
            end
        end
        pc = conv_chan;
        pk = conv_coef;
        pd = conv_data;
        gap = cyc - last_pop;
        last_pop = cyc;
        chk("pop_wait", 0, n >= 400 || s > 4);
    endtask : pop
    // two lines of five pixels each, channel order cyclic over len entries of chs
    task automatic run_seq(input logic [31:0] ctrl, input logic [5:0] chs, input int len, input int mg);
        logic [1:0] e;
        apb(1'b1, ADDR_CTRL, ctrl);
        for (int l = 0; l < 2; l++)
        begin
            line();
            for (int i = 0; i < 5; i++)
            begin
                pop(i == 0);
                e = chs[2*(i%len) +: 2];
                chk("chan", e, pc);
                chk("data", ev[e], pd);
                chk("coef", 0, pk);
                if (i > 0)
                    chk("gap_ok", 1, gap >= mg);
            end
        end
    endtask : run_seq
    // line coefficient stepping in single-input mode
    task automatic coef_seq(input logic [1:0] sel, input bit dsc, input logic [2:0] n);
        apb(1'b1, ADDR_CTRL, {20'h0, dsc, n, sel, 6'h00});
        for (int i = 0; i < 6; i++)
        begin
            line();
            pop(1'b1);
            chk("chan", sel, pc);
            chk("coef", sel != CH_RED ? 0 : (dsc ? n - 1 - (i % n) : i % n), pk);
        end
    endtask : coef_seq
    // fifo fills while the converter side stalls, then drains in order
    task automatic stall();
        apb(1'b1, ADDR_CTRL, {30'h0, MODE_THREE});
        line();
        pop(1'b1);
        conv_ready <= 1'b0;
        repeat (80) @(posedge pclk);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("fifo_full", 1, rq[7]);
        chk("valid_held", 1, conv_valid);
        conv_ready <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            p = pc;
            pop(1'b0);
            chk("chan_next", p == 2 ? 0 : p + 1, pc);
            chk("data", ev[pc], pd);
        end
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("fifo_full", 0, rq[7]);
    endtask : stall
    task automatic regs_at_reset();
        repeat (20) @(posedge pclk);
        chk("idle_valid", 0, conv_valid);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", CTRL_RST, rq);
        apb(1'b0, ADDR_DIV, 32'h0);
        chk("div", DIV_RST, rq);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, i < 3 ? ADDR_CHAN + 8'(4*i) : ADDR_LINE + 8'(4*(i-3)), 32'h0);
            chk("coef_reg", COEF_RST, rq);
        end
        apb(1'b1, 8'hfc, 32'h1234);
        chk("err_wr", 1, re);
        apb(1'b0, 8'hfc, 32'h0);
        chk("err_rd", 1, re);
        chk("rd_zero", 0, rq);
    endtask : regs_at_reset
    // main sequence
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_ready = 1'b1;
        presetn = 1'b0;
        mismatches = 0;
        checks_done = 0;
        cyc = 0;
        last_pop = 0;
        lnum = 4'h0;
        ro = 0;
        rg = 64;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        regs_at_reset();
        for (r = 0; r < 2; r++)
            for (pr = 0; pr < 2; pr++)
                run_seq({28'h0, r[0], pr[0], MODE_THREE}, r ? {CH_RED, CH_GREEN, CH_BLUE} :
                    {CH_BLUE, CH_GREEN, CH_RED}, 3, CONV_MIN_CYC_MULTI);
        for (p = 0; p < 3; p++)
            for (r = 0; r < 2; r++)
                for (pr = 0; pr < 2; pr++)
                begin
                    ev_n = p == 1 ? CH_RED : CH_BLUE;
                    od_n = p == 2 ? CH_RED : CH_GREEN;
                    run_seq({26'h0, p[1:0], r[0], pr[0], MODE_TWO}, r ? {2'b00, ev_n, od_n} : {2'b00, od_n, ev_n},
                        2, CONV_MIN_CYC_MULTI);
                end
        for (p = 0; p < 3; p++)
            run_seq({24'h0, p[1:0], 6'h00}, {4'h0, p[1:0]}, 1, CONV_MIN_CYC_SINGLE);
        coef_seq(CH_RED, 1'b0, 3'd5);
        coef_seq(CH_RED, 1'b1, 3'd3);
        coef_seq(CH_GREEN, 1'b0, 3'd3);
        stall();
        apb(1'b1, ADDR_CHAN, 32'h8010);
        apb(1'b0, ADDR_CHAN, 32'h0);
        chk("red_coef", 32'h8010, rq);
        ro = 16;
        rg = 128;
        run_seq({30'h0, MODE_THREE}, {CH_BLUE, CH_GREEN, CH_RED}, 3, CONV_MIN_CYC_MULTI);
        print_verdict();
    end
endmodule : amss_sequencer_test
